// ===== core/ftl_consts.svh
// Register offsets, field positions, reset values and widths of the fault log trigger bank.
`ifndef FTL_CONSTS_SVH
`define FTL_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FTL_OFS_LOG_CTL      8'h47
`define FTL_OFS_OV_LOW       8'h49
`define FTL_OFS_OV_HIGH      8'h4a
`define FTL_OFS_EW_LOW       8'h4b
`define FTL_OFS_EW_HIGH      8'h4c
`define FTL_OFS_UNLOCK       8'h5d

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define FTL_MAX_CH           12
`define FTL_UNLOCK_BIT       1
`define FTL_OV_LOW_LSB       4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FTL_RST_OV_EN        12'h000
`define FTL_RST_EW_EN        12'h000
`define FTL_RST_LOG_CTL      2'h0
`define FTL_RST_LOCKED       1'b0

`endif

// ===== core/ftl_pkg.sv
// Types shared by the fault log trigger bank.
package ftl_pkg;

   // ----------------------------------------------------------------------
   // Log content selector
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      FTL_SAVE_BOTH,
      FTL_SAVE_FLAGS,
      FTL_SAVE_VALUES,
      FTL_SAVE_NONE
   } ftl_log_mode_t;

   // ----------------------------------------------------------------------
   // Register access carrier
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ftl_reg_req_t;

   // ----------------------------------------------------------------------
   // Log command carrier
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic        start;
      logic        save_flags;
      logic        save_values;
      logic [11:0] lines;
   } ftl_log_cmd_t;

   // ----------------------------------------------------------------------
   // Module state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [11:0] hit;
   } ftl_bank_t;

   typedef struct packed {
      logic [11:0]   ov_en;
      logic [11:0]   ew_en;
      ftl_log_mode_t log_ctl;
      logic          locked;
      ftl_log_cmd_t  cmd;
      logic [7:0]    rdata;
   } ftl_state_t;

endpackage : ftl_pkg

// ===== core/ftl_trig_bank.sv
// Per-channel trigger qualification of comparator faults by their enables.
`timescale 1ns/1ps
`include "ftl_consts.svh"

module ftl_trig_bank #(
   parameter int NUM_CH = `FTL_MAX_CH
) (
   // Clock and reset.
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   // Comparator faults.
   input  wire logic [`FTL_MAX_CH-1:0]   ov_fault,
   input  wire logic [`FTL_MAX_CH-1:0]   ew_fault,
   // Trigger enables.
   input  wire logic [`FTL_MAX_CH-1:0]   ov_en,
   input  wire logic [`FTL_MAX_CH-1:0]   ew_en,
   // Qualified triggers.
   output logic      [`FTL_MAX_CH-1:0]   hit
);
   import ftl_pkg::*;

   ftl_bank_t                 s_q;
   ftl_bank_t                 s_d;
   logic [`FTL_MAX_CH-1:0]    hit_d;

   // ----------------------------------------------------------------------
   // Channel qualification
   // ----------------------------------------------------------------------
   for (genvar i = 0; i < `FTL_MAX_CH; i++) begin : g_ch
      if (i < NUM_CH) begin : g_on
         assign hit_d[i] = (ov_fault[i] & ov_en[i]) | (ew_fault[i] & ew_en[i]);
      end else begin : g_off
         assign hit_d[i] = 1'b0;
      end
   end

   always_comb begin
      s_d     = s_q;
      s_d.hit = hit_d;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign hit = s_q.hit;

endmodule : ftl_trig_bank

// ===== core/ftl_top.sv
// Fault log trigger enable bank with log control and storage lock.
`timescale 1ns/1ps
`include "ftl_consts.svh"

module ftl_top #(
   parameter int NUM_CH = `FTL_MAX_CH
) (
   // Clock and reset.
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   // Configuration register port.
   input  wire ftl_pkg::ftl_reg_req_t    reg_req,
   output logic      [7:0]               reg_rdata,
   // Comparator faults.
   input  wire logic [`FTL_MAX_CH-1:0]   ov_fault,
   input  wire logic [`FTL_MAX_CH-1:0]   ew_fault,
   // Log request to storage.
   output ftl_pkg::ftl_log_cmd_t         log_cmd,
   output logic                          log_locked
);
   import ftl_pkg::*;

   localparam logic [`FTL_MAX_CH-1:0] CH_MASK =
      `FTL_MAX_CH'((13'h1 << NUM_CH) - 13'h1);

   ftl_state_t                s_q;
   ftl_state_t                s_d;
   logic [`FTL_MAX_CH-1:0]    hit;
   logic                      hit_any;
   logic                      fire;
   logic                      unlock;

   // ----------------------------------------------------------------------
   // Trigger qualification
   // ----------------------------------------------------------------------
   ftl_trig_bank #(
      .NUM_CH   (NUM_CH)
   ) u_bank (
      .clk      (clk),
      .reset_n  (reset_n),
      .ov_fault (ov_fault),
      .ew_fault (ew_fault),
      .ov_en    (s_q.ov_en),
      .ew_en    (s_q.ew_en),
      .hit      (hit)
   );

   assign hit_any = |hit;
   assign fire    = hit_any && !s_q.locked && (s_q.log_ctl != FTL_SAVE_NONE);
   assign unlock  = reg_req.wr && (reg_req.addr == `FTL_OFS_UNLOCK)
                    && reg_req.wdata[`FTL_UNLOCK_BIT];

   // ----------------------------------------------------------------------
   // Register access and log control
   // ----------------------------------------------------------------------
   always_comb begin
      s_d           = s_q;
      s_d.cmd.start = 1'b0;
      s_d.rdata     = 8'h00;
      if (reg_req.wr) begin
         unique case (reg_req.addr)
            `FTL_OFS_LOG_CTL: begin
               s_d.log_ctl = ftl_log_mode_t'(reg_req.wdata[1:0]);
            end
            `FTL_OFS_OV_LOW: begin
               s_d.ov_en[3:0] = reg_req.wdata[7:`FTL_OV_LOW_LSB];
            end
            `FTL_OFS_OV_HIGH: begin
               s_d.ov_en[11:4] = reg_req.wdata & CH_MASK[11:4];
            end
            `FTL_OFS_EW_LOW: begin
               s_d.ew_en[7:0] = reg_req.wdata;
            end
            `FTL_OFS_EW_HIGH: begin
               s_d.ew_en[11:8] = reg_req.wdata[3:0] & CH_MASK[11:8];
            end
            default: begin
               s_d.ov_en = s_q.ov_en;
            end
         endcase
      end
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            `FTL_OFS_LOG_CTL: s_d.rdata = {6'h00, s_q.log_ctl};
            `FTL_OFS_OV_LOW:  s_d.rdata = {s_q.ov_en[3:0], 4'h0};
            `FTL_OFS_OV_HIGH: s_d.rdata = s_q.ov_en[11:4];
            `FTL_OFS_EW_LOW:  s_d.rdata = s_q.ew_en[7:0];
            `FTL_OFS_EW_HIGH: s_d.rdata = {4'h0, s_q.ew_en[11:8]};
            `FTL_OFS_UNLOCK:  s_d.rdata = {6'h00, s_q.locked, 1'b0};
            default:          s_d.rdata = 8'h00;
         endcase
      end
      if (unlock) begin
         s_d.locked = 1'b0;
      end
      if (fire) begin
         s_d.locked          = 1'b1;
         s_d.cmd.start       = 1'b1;
         s_d.cmd.save_flags  = (s_q.log_ctl == FTL_SAVE_BOTH)
                               || (s_q.log_ctl == FTL_SAVE_FLAGS);
         s_d.cmd.save_values = (s_q.log_ctl == FTL_SAVE_BOTH)
                               || (s_q.log_ctl == FTL_SAVE_VALUES);
         s_d.cmd.lines       = hit;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q.ov_en   <= `FTL_RST_OV_EN;
         s_q.ew_en   <= `FTL_RST_EW_EN;
         s_q.log_ctl <= ftl_log_mode_t'(`FTL_RST_LOG_CTL);
         s_q.locked  <= `FTL_RST_LOCKED;
         s_q.cmd     <= '0;
         s_q.rdata   <= 8'h00;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata  = s_q.rdata;
   assign log_cmd    = s_q.cmd;
   assign log_locked = s_q.locked;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   chk_ov_low_group: assert property (
      (|(ov_fault[2:0] & s_q.ov_en[2:0])) |=> hit_any)
      else $error("Overvoltage on inputs 1 to 3 did not trigger.");

   chk_ov_input_four: assert property (
      (ov_fault[3] && s_q.ov_en[3]) |=> hit[3])
      else $error("Overvoltage on input 4 did not trigger.");

   chk_ov_mid_group: assert property (
      (|(ov_fault[7:4] & s_q.ov_en[7:4])) |=> hit_any)
      else $error("Overvoltage on inputs 5 to 8 did not trigger.");

   chk_ov_high_group: assert property (
      (|(ov_fault[11:8] & s_q.ov_en[11:8])) |=> (|hit[11:8]))
      else $error("Overvoltage on inputs 9 to 12 did not trigger.");

   chk_ew_low_group: assert property (
      (|(ew_fault[7:0] & s_q.ew_en[7:0])) ##1 (!s_q.locked && s_q.log_ctl != FTL_SAVE_NONE)
      |=> log_cmd.start)
      else $error("Early warning on inputs 1 to 8 did not start a log.");

   chk_ew_high_group: assert property (
      (|(ew_fault[11:8] & s_q.ew_en[11:8])) |=> (|hit[11:8]))
      else $error("Early warning on inputs 9 to 12 did not trigger.");

   chk_upper_bits_zero: assert property (
      (reg_req.rd && reg_req.addr == `FTL_OFS_EW_HIGH) |=> (reg_rdata[7:4] == 4'h0))
      else $error("Unused early warning bits read as nonzero.");

   chk_variant_mask: assert property (
      (s_q.ov_en & ~CH_MASK) == '0 && (s_q.ew_en & ~CH_MASK) == '0)
      else $error("Enable stored for an absent input.");

   chk_mode_contents: assert property (
      log_cmd.start |-> (log_cmd.save_flags == ($past(s_q.log_ctl) inside
         {FTL_SAVE_BOTH, FTL_SAVE_FLAGS})) && $past(s_q.log_ctl) != FTL_SAVE_NONE)
      else $error("Log contents do not follow the selector.");

   chk_lock_after_log: assert property (
      log_cmd.start |-> log_locked ##1 (log_locked || $past(unlock)))
      else $error("Storage not locked after a log event.");

   chk_no_log_locked: assert property (
      (s_q.locked && !unlock) |=> !log_cmd.start)
      else $error("Log started while storage was locked.");

   chk_start_pulse: assert property (
      log_cmd.start |=> !log_cmd.start)
      else $error("Log start lasted more than one cycle.");

   chk_start_needs_hit: assert property (
      log_cmd.start |-> $past(hit_any))
      else $error("Log started without a qualified trigger.");

   chk_lines_nonzero: assert property (
      log_cmd.start |-> (log_cmd.lines != '0))
      else $error("Log started with no failed line recorded.");

   chk_values_follow_sel: assert property (
      log_cmd.start |-> (log_cmd.save_values == ($past(s_q.log_ctl) inside
         {FTL_SAVE_BOTH, FTL_SAVE_VALUES})))
      else $error("Saved values flag does not follow the selector.");

   chk_disabled_no_log: assert property (
      (s_q.log_ctl == FTL_SAVE_NONE) |=> !log_cmd.start)
      else $error("Log started while the logger was off.");

   chk_mode_write: assert property (
      (reg_req.wr && reg_req.addr == `FTL_OFS_LOG_CTL)
      |=> (s_q.log_ctl == $past(reg_req.wdata[1:0])))
      else $error("Log selector write did not take effect.");

   chk_unlock_clears: assert property (
      (unlock && !fire) |=> !log_locked)
      else $error("Unlock write did not release the storage.");

   chk_ov_four_write: assert property (
      (reg_req.wr && reg_req.addr == `FTL_OFS_OV_LOW)
      |=> (s_q.ov_en[3] == $past(reg_req.wdata[7])))
      else $error("Input 4 overvoltage enable not taken from bit 7.");

   chk_ov_high_write: assert property (
      (reg_req.wr && reg_req.addr == `FTL_OFS_OV_HIGH)
      |=> (s_q.ov_en[7:4] == $past(reg_req.wdata[3:0])))
      else $error("Inputs 5 to 8 overvoltage enables not stored.");

   chk_ew_low_write: assert property (
      (reg_req.wr && reg_req.addr == `FTL_OFS_EW_LOW)
      |=> (s_q.ew_en[7:0] == $past(reg_req.wdata)))
      else $error("Early warning enables for inputs 1 to 8 not stored.");

endmodule : ftl_top

// ===== verif/tb_fault_log_trigger_select.sv
// Self-checking testbench of the fault log trigger enable bank.
`timescale 1ns/1ps
`include "ftl_consts.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_fault_log_trigger_select;
   import ftl_pkg::*;
   // ----------------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------------
   logic         clk;
   logic         reset_n;
   ftl_reg_req_t reg_req;
   logic [7:0]   reg_rdata;
   logic [11:0]  ov_fault;
   logic [11:0]  ew_fault;
   ftl_log_cmd_t log_cmd;
   logic         log_locked;
   int           n_errors;
   int           num_checks;
   logic [31:0]  seed;
   logic [31:0]  r;
   logic [7:0]   rd;
   logic [7:0]   wd;
   logic [1:0]   sel;
   logic [11:0]  ov_e;
   logic [11:0]  ew_e;
   logic [11:0]  ov_f;
   logic [11:0]  ew_f;
   logic [11:0]  exp_l;
   bit           got;
   logic [7:0]   addrs [7] = '{8'h47, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h5d, 8'h50};

   ftl_top #(.NUM_CH(12)) dut_u (
      .clk        (clk),
      .reset_n    (reset_n),
      .reg_req    (reg_req),
      .reg_rdata  (reg_rdata),
      .ov_fault   (ov_fault),
      .ew_fault   (ew_fault),
      .log_cmd    (log_cmd),
      .log_locked (log_locked)
   );

   initial clk = 1'b0;
   always #10 clk = ~clk;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic logic [7:0] reg_mask(input logic [7:0] a);
      case (a)
         `FTL_OFS_LOG_CTL: return 8'h03;
         `FTL_OFS_OV_LOW:  return 8'hf0;
         `FTL_OFS_OV_HIGH: return 8'hff;
         `FTL_OFS_EW_LOW:  return 8'hff;
         `FTL_OFS_EW_HIGH: return 8'h0f;
         default:          return 8'h00;
      endcase
   endfunction : reg_mask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_req.wr    <= 1'b1;
      reg_req.addr  <= a;
      reg_req.wdata <= d;
      @(posedge clk);
      reg_req.wr    <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_req.rd   <= 1'b1;
      reg_req.addr <= a;
      @(posedge clk);
      reg_req.rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rdr

   task automatic set_en(input logic [11:0] o, input logic [11:0] e);
      wr(`FTL_OFS_OV_LOW, {o[3:0], 4'h0});
      wr(`FTL_OFS_OV_HIGH, o[11:4]);
      wr(`FTL_OFS_EW_LOW, e[7:0]);
      wr(`FTL_OFS_EW_HIGH, {4'h0, e[11:8]});
   endtask : set_en

   task automatic wait_start(output bit g);
      g = 1'b0;
      for (int i = 0; i < 6 && !g; i++) begin
         @(posedge clk);
         #1;
         g = (log_cmd.start === 1'b1);
      end
   endtask : wait_start

   task automatic set_faults(input logic [11:0] o, input logic [11:0] e);
      @(posedge clk);
      ov_fault <= o;
      ew_fault <= e;
   endtask : set_faults

   task automatic test_done();
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   // ----------------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------------
   initial begin
      #100000;
      n_errors++;
      test_done();
   end

   initial begin
      reset_n = 1'b0;
      reg_req = '0;
      ov_fault = '0;
      ew_fault = '0;
      seed = 32'h36e7;
      n_errors = 0;
      num_checks = 0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      `CHK(log_locked, 1'b0)
      foreach (addrs[i]) begin
         rdr(addrs[i], rd);
         `CHK(rd, 8'h00)
         r = xs();
         wd = r[7:0];
         wr(addrs[i], wd);
         rdr(addrs[i], rd);
         `CHK(rd, wd & reg_mask(addrs[i]))
      end
      $display("register test done");
      for (int k = 0; k < 24; k++) begin
         sel = 2'(k % 3);
         r = xs();
         {ov_e, ew_e} = r[23:0];
         r = xs();
         {ov_f, ew_f} = r[23:0];
         if (k < 12) begin
            ov_e[k] = 1'b1;
            ov_f[k] = 1'b1;
         end else begin
            ew_e[k - 12] = 1'b1;
            ew_f[k - 12] = 1'b1;
         end
         exp_l = (ov_f & ov_e) | (ew_f & ew_e);
         wr(`FTL_OFS_LOG_CTL, {6'h00, sel});
         set_en(ov_e, ew_e);
         set_faults(ov_f, ew_f);
         wait_start(got);
         `CHK(got, 1'b1)
         `CHK(log_cmd.lines, exp_l)
         `CHK(log_cmd.save_flags, sel != 2'd2)
         `CHK(log_cmd.save_values, sel != 2'd1)
         `CHK(log_locked, 1'b1)
         rdr(`FTL_OFS_UNLOCK, rd);
         `CHK(rd, 8'h02)
         @(posedge clk);
         #1;
         `CHK(reg_rdata, 8'h00)
         wait_start(got);
         `CHK(got, 1'b0)
         set_faults(12'h000, 12'h000);
         wr(`FTL_OFS_UNLOCK, 8'h02);
         @(posedge clk);
         #1;
         `CHK(log_locked, 1'b0)
      end
      $display("trigger test done");
      for (int k = 0; k < 2; k++) begin
         wr(`FTL_OFS_LOG_CTL, k ? 8'h03 : 8'h00);
         set_en(k ? 12'hfff : 12'h000, k ? 12'hfff : 12'h000);
         set_faults(12'hfff, 12'hfff);
         wait_start(got);
         `CHK(got, 1'b0)
         `CHK(log_locked, 1'b0)
         set_faults(12'h000, 12'h000);
      end
      $display("suppress test done");
      test_done();
   end
endmodule : tb_fault_log_trigger_select
